// [design/pps_pkg.sv]
`default_nettype none
package pps_pkg;
  // ****************************************
  // whitening register
  // ****************************************
  localparam int SCR_W      = 33;
  localparam int TAP_MASTER = 13;
  localparam int TAP_SLAVE  = 20;
  localparam int SX_BIT0    = 3;
  localparam int SX_BIT1    = 8;
  localparam int SY_BIT0    = 4;
  localparam int SY_BIT1    = 6;
  localparam int SA_SIGN0   = 1;
  localparam int SA_SIGN1   = 5;
  localparam int SB_SIGN0   = 2;
  localparam int SB_SIGN1   = 12;
  localparam int SWAP_BIT   = 0;
  localparam logic [SCR_W-1:0] SCR_RESET = 33'h0_0000_0001;
  localparam logic [SCR_W-1:0] ENT_RESET = 33'h1_5a5a_c3c3;
  // ****************************************
  // timing
  // ****************************************
  localparam int SYM_NS     = 40;
  localparam int CLK_NS     = 100;
  localparam int SYM_CYCLES = (SYM_NS / CLK_NS) < 1 ? 1 : SYM_NS / CLK_NS;
  // ****************************************
  // code words and levels
  // ****************************************
  localparam int LVL_W = 3;
  localparam logic [2:0] CW_ESC = 3'h4;
  localparam logic [LVL_W-1:0] LV_M2 = 3'h6;
  localparam logic [LVL_W-1:0] LV_M1 = 3'h7;
  localparam logic [LVL_W-1:0] LV_0  = 3'h0;
  localparam logic [LVL_W-1:0] LV_P1 = 3'h1;
  localparam logic [LVL_W-1:0] LV_P2 = 3'h2;
  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_SEED   = 8'h08;
  localparam int CTRL_MASTER = 0;
  localparam int CTRL_SENDN  = 1;
  localparam int CTRL_SWAP   = 2;
  localparam int CTRL_RESEED = 3;
  localparam logic MASTER_RST = 1'b1;
  localparam logic SENDN_RST  = 1'b1;
  localparam logic SWAP_RST   = 1'b0;
  localparam logic [DATA_W-1:0] SEED_RST = 32'h0000_0000;
  localparam int ST_LOCOK  = 0;
  localparam int ST_RECV   = 1;
  localparam int ST_POLINV = 2;
  localparam int ST_TXEN   = 3;
  localparam int ST_ODD    = 4;
  // ****************************************
  // receive states
  // ****************************************
  typedef enum logic [2:0] {
    RX_HUNT = 3'b001,
    RX_IDLE = 3'b010,
    RX_DATA = 3'b100
  } pps_rxst_t;
endpackage
`default_nettype wire

// [design/pps_lane_map.sv]
`timescale 1ns/1ps
`default_nettype none
module pps_lane_map #(
  parameter int LW = pps_pkg::LVL_W
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // code word in
  input  wire logic          tick,
  input  wire logic [2:0]    codeWord,
  input  wire logic          negate,
  // level out
  output logic      [LW-1:0] level
);
  import pps_pkg::*;

  logic [LW-1:0] levelQ;
  logic [LW-1:0] plainLvl;
  logic [LW-1:0] outLvl;

  // ****************************************
  // gray-coded five-level mapping
  // ****************************************
  // RULE16 - level table
  always_comb begin
    casez (codeWord)
      3'b1??:  plainLvl = LV_M2;
      3'b000:  plainLvl = LV_0;
      3'b001:  plainLvl = LV_P1;
      3'b011:  plainLvl = LV_P2;
      3'b010:  plainLvl = LV_M1;
      default: plainLvl = LV_0;
    endcase
  end

  // RULE15 - sign flip
  assign outLvl = negate ? LW'(-plainLvl) : plainLvl;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      levelQ <= LV_0;
    end else if (tick) begin
      levelQ <= outLvl;
    end
  end

  assign level = levelQ;
endmodule
`default_nettype wire

// [design/pps_encoder.sv]
// Overview of operation
// RULE1 - whitening register steps, master/slave taps
// RULE2 - every reset reseeds all 33 bits
// RULE3 - one symbol pair per period
// RULE4 - mix bits from fixed register taps
// RULE5 - first pair follows parity or health
// RULE6 - second pair follows parity and history
// RULE7 - sign bits and lane pair swap
// RULE8 - idle-only mode forces data inactive
// RULE9 - start marker replaces first preamble
// RULE10 - top code bit selects outer level
// RULE11 - data nibble code words
// RULE12 - transmit error uses outer and zero
// RULE13 - end marker after last nibble
// RULE14 - idle code words from whitening
// RULE15 - gray map and lane negation
// RULE16 - fixed five-level code table
// RULE17 - idle pairing and outer-level slot
// RULE18 - receiver uses idle pairing to align; the code takes lane order from the CTRL_SWAP register bit instead
// RULE19 - receiver resolves polarity on minus two
// RULE20 - receiver reports local health
// RULE21 - receiver produces mii data, receiving
// RULE22 - mac gives one nibble per period
`timescale 1ns/1ps
`default_nettype none
module pps_encoder #(
  parameter logic [7:0] OK_THRESH  = 8'h40,
  parameter logic [7:0] POL_THRESH = 8'h08
) (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  // register port
  input  wire logic [pps_pkg::ADDR_W-1:0]     regAddr,
  input  wire logic [pps_pkg::DATA_W-1:0]     regWrData,
  input  wire logic                           regWr,
  input  wire logic                           regRd,
  output logic      [pps_pkg::DATA_W-1:0]     regRdData,
  // mii transmit
  input  wire logic [3:0]                     txd,
  input  wire logic                           txEn,
  input  wire logic                           txErr,
  // symbols to the medium
  output logic      [pps_pkg::LVL_W-1:0]      wirePairA,
  output logic      [pps_pkg::LVL_W-1:0]      wirePairB,
  output logic                                txSymValid,
  // symbols from the medium
  input  wire logic [pps_pkg::LVL_W-1:0]      pmaRxA,
  input  wire logic [pps_pkg::LVL_W-1:0]      pmaRxB,
  // mii receive and status
  output logic      [3:0]                     rxd,
  output logic                                rxDv,
  output logic                                rxErr,
  output logic                                receiving,
  output logic                                locRcvrOk
);
  import pps_pkg::*;

  localparam logic [7:0] SYM_LAST = 8'(SYM_CYCLES - 1);

  logic              cfgMasterQ;
  logic              sendNormalQ;
  logic              swapLanesQ;
  logic              reseedQ;
  logic [DATA_W-1:0] seedQ;
  logic [DATA_W-1:0] rdDataQ;
  logic [DATA_W-1:0] statusWord;
  logic              wrCtrl;
  logic [7:0]        symCntQ;
  logic              tick;
  logic [SCR_W-1:0]  entQ;
  logic [SCR_W-1:0]  entMix;
  logic [SCR_W-1:0]  scrQ;
  logic [SCR_W-1:0]  scrLastQ;
  logic [SCR_W-1:0]  seedVal;
  logic              seedPendQ;
  logic              loadNow;
  logic              fb;
  logic              oddQ;
  logic              mixBitOne;
  logic              mixBitTwo;
  logic              mixTwoPrevQ;
  logic              x0;
  logic              y0;
  logic [1:0]        xPair;
  logic [1:0]        yPair;
  logic [2:0]        aLaneWhiteningWord;
  logic [2:0]        bLaneWhiteningWord;
  logic              dataActive;
  logic              en1Q;
  logic              en2Q;
  logic [2:0]        aLaneCodeWord;
  logic [2:0]        bLaneCodeWord;
  logic              txSymValidQ;
  logic [LVL_W-1:0]  rxA;
  logic [LVL_W-1:0]  rxB;
  logic [LVL_W-1:0]  alignedLaneARxQ;
  logic [LVL_W-1:0]  alignedLaneBRxQ;
  logic [LVL_W-1:0]  prevAQ;
  logic [LVL_W-1:0]  prevBQ;
  logic              polInvQ;
  logic [7:0]        goodCntQ;
  logic [7:0]        polFailCntQ;
  logic              locOkQ;
  logic              pairOk;
  logic              minusTwoBad;
  logic              delimHit;
  logic              delimPart;
  pps_rxst_t         rxStQ;
  pps_rxst_t         rxStD;
  logic [3:0]        rxdQ;
  logic              rxDvQ;
  logic              rxErrQ;

  function automatic logic isTwo(input logic [LVL_W-1:0] l);
    isTwo = (l == LV_P2) || (l == LV_M2);
  endfunction

  function automatic logic [1:0] qBits(input logic [LVL_W-1:0] l);
    qBits = (l == LV_0) ? 2'h0 : (l[0] ? 2'h1 : 2'h3);
  endfunction

  // ****************************************
  // register port
  // ****************************************
  assign wrCtrl = regWr && (regAddr == REG_CTRL);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfgMasterQ  <= MASTER_RST;
      sendNormalQ <= SENDN_RST;
      swapLanesQ  <= SWAP_RST;
    end else if (wrCtrl) begin
      cfgMasterQ  <= regWrData[CTRL_MASTER];
      sendNormalQ <= regWrData[CTRL_SENDN];
      swapLanesQ  <= regWrData[CTRL_SWAP];
    end
  end

  // reseed is a self-clearing pulse, it reads back as zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reseedQ <= 1'b0;
    end else begin
      reseedQ <= wrCtrl && regWrData[CTRL_RESEED];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seedQ <= SEED_RST;
    end else if (regWr && (regAddr == REG_SEED)) begin
      seedQ <= regWrData;
    end
  end

  assign statusWord = {27'h0, oddQ, dataActive, polInvQ,
                       (rxStQ == RX_DATA), locOkQ};

  // read data stand for one cycle only, unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdDataQ <= '0;
    end else if (regRd) begin
      case (regAddr)
        REG_CTRL:   rdDataQ <= {29'h0, swapLanesQ, sendNormalQ, cfgMasterQ};
        REG_STATUS: rdDataQ <= statusWord;
        REG_SEED:   rdDataQ <= seedQ;
        default:    rdDataQ <= '0;
      endcase
    end else begin
      rdDataQ <= '0;
    end
  end

  assign regRdData = rdDataQ;

  // ****************************************
  // symbol period
  // ****************************************
  // RULE3 - period tick
  assign tick = (symCntQ == SYM_LAST);

  always_ff @(posedge clk) begin
    if (!rst_n || tick) begin
      symCntQ <= 8'h00;
    end else begin
      symCntQ <= symCntQ + 8'h01;
    end
  end

  // ****************************************
  // random source and whitening register
  // ****************************************
  // the entropy source mixes the seed register and line noise each clock
  assign entMix = {1'b0, seedQ} ^ {27'h0, pmaRxA, pmaRxB};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      entQ <= ENT_RESET;
    end else begin
      entQ <= {entQ[SCR_W-2:0], entQ[SCR_W-1] ^ entQ[TAP_SLAVE-1]} ^ entMix;
    end
  end

  // an all-zero load would lock the whitening register up
  assign seedVal = (entQ == '0) ? SCR_RESET : entQ;
  assign loadNow = seedPendQ || reseedQ;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seedPendQ <= 1'b1;
    end else begin
      seedPendQ <= 1'b0;
    end
  end

  assign fb = scrQ[SCR_W-1] ^ (cfgMasterQ ? scrQ[TAP_MASTER-1] : scrQ[TAP_SLAVE-1]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scrQ <= SCR_RESET;
    // RULE2 - random reload
    end else if (loadNow) begin
      scrQ <= seedVal;
    // RULE1 - shift one bit
    end else if (tick) begin
      scrQ <= {scrQ[SCR_W-2:0], fb};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || loadNow) begin
      oddQ <= 1'b0;
    end else if (tick) begin
      oddQ <= !oddQ;
    end
  end

  // ****************************************
  // whitening words
  // ****************************************
  // RULE4 - mix bits
  assign mixBitOne = scrQ[SX_BIT0] ^ scrQ[SX_BIT1];
  assign mixBitTwo = scrQ[SY_BIT0] ^ scrQ[SY_BIT1];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mixTwoPrevQ <= 1'b0;
    end else if (tick) begin
      mixTwoPrevQ <= mixBitTwo;
    end
  end

  // RULE5 - first alternate pair
  assign x0    = (!oddQ || locOkQ) ? mixBitOne : !mixBitOne;
  assign xPair = {!x0, x0};
  // RULE6 - second alternate pair
  assign y0    = !oddQ ? mixBitTwo : !mixTwoPrevQ;
  assign yPair = {y0, y0};

  // RULE7 - signs and lane swap
  assign aLaneWhiteningWord = {scrQ[SA_SIGN0] ^ scrQ[SA_SIGN1],
                               scrQ[SWAP_BIT] ? xPair : yPair};
  assign bLaneWhiteningWord = {scrQ[SB_SIGN0] ^ scrQ[SB_SIGN1],
                               scrQ[SWAP_BIT] ? yPair : xPair};

  // ****************************************
  // code words
  // ****************************************
  // RULE8 - idle-only mode
  assign dataActive = sendNormalQ && txEn;

  // RULE9 RULE13 - enable history
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en1Q <= 1'b0;
      en2Q <= 1'b0;
    end else if (tick) begin
      en1Q <= dataActive;
      en2Q <= en1Q;
    end
  end

  // RULE10 - a top bit of one maps to the outer level
  always_comb begin
    if (dataActive && !en2Q) begin
      // RULE9 - start marker
      aLaneCodeWord = CW_ESC;
      bLaneCodeWord = {!en1Q, en2Q, en2Q};
    end else if (dataActive && txErr) begin
      // RULE12 - error code
      aLaneCodeWord = {aLaneWhiteningWord[1] ^ aLaneWhiteningWord[0], 2'h0};
      bLaneCodeWord = {bLaneWhiteningWord[1] ^ bLaneWhiteningWord[0], 2'h0};
    end else if (dataActive) begin
      // RULE11 - data nibble
      aLaneCodeWord = {1'b0, aLaneWhiteningWord[1] ^ txd[3],
                       aLaneWhiteningWord[0] ^ txd[2] ^ 1'b1};
      bLaneCodeWord = {1'b0, bLaneWhiteningWord[1] ^ txd[1],
                       bLaneWhiteningWord[0] ^ txd[0] ^ 1'b1};
    end else if (en2Q) begin
      // RULE13 - end marker
      aLaneCodeWord = CW_ESC;
      bLaneCodeWord = {en1Q, !en2Q, !en2Q};
    end else begin
      // RULE14 - idle code
      aLaneCodeWord = {1'b0, aLaneWhiteningWord[1:0]};
      bLaneCodeWord = {1'b0, bLaneWhiteningWord[1:0]};
    end
  end

  // ****************************************
  // level mapping
  // ****************************************
  // RULE15 - lane negation
  pps_lane_map #(.LW(LVL_W)) uMapA (
    .clk      (clk),
    .rst_n    (rst_n),
    .tick     (tick),
    .codeWord (aLaneCodeWord),
    .negate   (aLaneWhiteningWord[2] ^ en2Q),
    .level    (wirePairA)
  );

  pps_lane_map #(.LW(LVL_W)) uMapB (
    .clk      (clk),
    .rst_n    (rst_n),
    .tick     (tick),
    .codeWord (bLaneCodeWord),
    .negate   (bLaneWhiteningWord[2] ^ en2Q),
    .level    (wirePairB)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txSymValidQ <= 1'b0;
    end else begin
      txSymValidQ <= tick;
    end
  end

  assign txSymValid = txSymValidQ;

  // ****************************************
  // receive front end
  // ****************************************
  // RULE18 - lane alignment
  assign rxA = polInvQ ? LVL_W'(-(swapLanesQ ? pmaRxB : pmaRxA))
                       : (swapLanesQ ? pmaRxB : pmaRxA);
  assign rxB = polInvQ ? LVL_W'(-(swapLanesQ ? pmaRxA : pmaRxB))
                       : (swapLanesQ ? pmaRxA : pmaRxB);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alignedLaneARxQ <= LV_0;
      alignedLaneBRxQ <= LV_0;
      prevAQ          <= LV_0;
      prevBQ          <= LV_0;
    end else if (tick) begin
      alignedLaneARxQ <= rxA;
      alignedLaneBRxQ <= rxB;
      prevAQ          <= alignedLaneARxQ;
      prevBQ          <= alignedLaneBRxQ;
    end
  end

  // in idle exactly one lane carries an odd level
  assign pairOk = alignedLaneARxQ[0] ^ alignedLaneBRxQ[0];
  assign minusTwoBad = !pairOk && !delimPart &&
                       (alignedLaneARxQ == LV_M2 || alignedLaneBRxQ == LV_M2);
  assign delimHit = isTwo(prevAQ) && isTwo(prevBQ) &&
                    isTwo(alignedLaneARxQ) && (alignedLaneBRxQ == LV_0);
  // delimiters break the idle pairing on purpose and must cost no health
  assign delimPart = (isTwo(alignedLaneARxQ) && isTwo(alignedLaneBRxQ)) || delimHit;

  // RULE20 - health counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      goodCntQ <= 8'h00;
      locOkQ   <= 1'b0;
    end else if (tick && rxStQ != RX_DATA && !delimPart) begin
      if (!pairOk) begin
        goodCntQ <= 8'h00;
        locOkQ   <= 1'b0;
      end else if (goodCntQ != OK_THRESH) begin
        goodCntQ <= goodCntQ + 8'h01;
        locOkQ   <= (goodCntQ + 8'h01) == OK_THRESH;
      end
    end
  end

  assign locRcvrOk = locOkQ;

  // RULE19 - polarity search; a flip only helps when the failures
  // come from inverted wiring, so it is held back by a threshold
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      polFailCntQ <= 8'h00;
      polInvQ     <= 1'b0;
    end else if (tick && rxStQ != RX_DATA && minusTwoBad) begin
      if (polFailCntQ == POL_THRESH - 8'h01) begin
        polFailCntQ <= 8'h00;
        polInvQ     <= !polInvQ;
      end else begin
        polFailCntQ <= polFailCntQ + 8'h01;
      end
    end
  end

  // RULE21 - stream detection
  always_comb begin
    rxStD = rxStQ;
    case (rxStQ)
      RX_HUNT: if (locOkQ) rxStD = RX_IDLE;
      RX_IDLE: begin
        if (!locOkQ) begin
          rxStD = RX_HUNT;
        end else if (delimHit) begin
          rxStD = RX_DATA;
        end
      end
      RX_DATA: begin
        if (delimHit) begin
          rxStD = RX_IDLE;
        end else if (!locOkQ) begin
          rxStD = RX_HUNT;
        end
      end
      default: rxStD = RX_HUNT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxStQ <= RX_HUNT;
    end else if (tick) begin
      rxStQ <= rxStD;
    end
  end

  // descrambling of the receive nibble is not done here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxdQ   <= 4'h0;
      rxDvQ  <= 1'b0;
      rxErrQ <= 1'b0;
    end else if (tick) begin
      rxdQ   <= {qBits(alignedLaneARxQ), qBits(alignedLaneBRxQ)};
      rxDvQ  <= (rxStD == RX_DATA);
      rxErrQ <= (rxStQ == RX_DATA) && (rxStD == RX_HUNT);
    end
  end

  assign rxd       = rxdQ;
  assign rxDv      = rxDvQ;
  assign rxErr     = rxErrQ;
  assign receiving = (rxStQ == RX_DATA);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge clk) begin
    scrLastQ <= scrQ;
  end

  sequence startSeq;
    tick && dataActive && !en2Q;
  endsequence

  sequence endSeq;
    tick && !dataActive && en2Q;
  endsequence

  scr_step_a: assert property ( // RULE1
    tick && !loadNow ##1 1'b1 |->
      scrQ == {scrLastQ[SCR_W-2:0], scrLastQ[SCR_W-1] ^
        ($past(cfgMasterQ) ? scrLastQ[TAP_MASTER-1] : scrLastQ[TAP_SLAVE-1])})
    else $error("whitening step wrong");

  seed_load_a: assert property ( // RULE2
    loadNow |=> scrQ != '0 && !oddQ)
    else $error("reseed left register empty");

  sym_rate_a: assert property ( // RULE3
    tick |=> txSymValid ##0 $stable(symCntQ) || symCntQ == 8'h00)
    else $error("symbol pair missing");

  idle_only_a: assert property ( // RULE8
    !sendNormalQ |-> !dataActive && aLaneCodeWord[2] == en2Q)
    else $error("data active in idle-only mode");

  start_mark_a: assert property ( // RULE9
    startSeq |=> wirePairA == LV_M2 || wirePairA == LV_P2)
    else $error("start marker not outer level");

  err_code_a: assert property ( // RULE12
    tick && dataActive && en2Q && txErr |-> aLaneCodeWord[1:0] == 2'h0
      && bLaneCodeWord[1:0] == 2'h0)
    else $error("error code wrong");

  end_mark_a: assert property ( // RULE13
    endSeq |-> aLaneCodeWord == CW_ESC && bLaneCodeWord[2] == en1Q)
    else $error("end marker wrong");

  idle_pair_a: assert property ( // RULE17
    tick && !dataActive && !en2Q |=> wirePairA[0] != wirePairB[0])
    else $error("idle pairing broken");

  health_a: assert property ( // RULE20
    locOkQ |-> goodCntQ == OK_THRESH)
    else $error("health without full count");
endmodule
`default_nettype wire

// [testbench/pps_pma_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pps_pma_model (
  // clock
  input  wire logic                       clk,
  // levels sent by the encoder
  input  wire logic [pps_pkg::LVL_W-1:0]  txA,
  input  wire logic [pps_pkg::LVL_W-1:0]  txB,
  // zero pairs break idle pairing on purpose
  input  wire logic                       fault,
  // levels back to the receiver
  output logic      [pps_pkg::LVL_W-1:0]  rxA,
  output logic      [pps_pkg::LVL_W-1:0]  rxB
);
  // loopback keeps pairing
  // one period of line delay, same polarity and lane order as sent
  always_ff @(posedge clk) begin
    rxA <= fault ? 3'h0 : txA;
    rxB <= fault ? 3'h0 : txB;
  end
endmodule
`default_nettype wire

// [testbench/pps_encoder_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module pps_encoder_tb;
  import pps_pkg::*;
  logic              clk       = 1'b0;
  logic              rst_n     = 1'b0;
  logic [ADDR_W-1:0] regAddr   = 8'h00;
  logic [DATA_W-1:0] regWrData = 32'h0;
  logic              regWr     = 1'b0;
  logic              regRd     = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic [3:0]        txd       = 4'h0;
  logic              txEn      = 1'b0;
  logic              txErr     = 1'b0;
  logic              fault     = 1'b0;
  logic [LVL_W-1:0]  pA, pB, rA, rB;
  logic [3:0]        rxd;
  logic              txSymValid, rxDv, rxErr, receiving, locRcvrOk;
  logic              sawRecv   = 1'b0;
  logic              sawDv     = 1'b0;
  logic              sawRxErr  = 1'b0;
  int                errorCnt  = 0;
  int                testsRun  = 0;
  int                cyc       = 0;
  logic [31:0]       v;

  pps_encoder #(.OK_THRESH(8'h04), .POL_THRESH(8'h02)) dut (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .txd(txd),
    .txEn(txEn), .txErr(txErr), .wirePairA(pA), .wirePairB(pB),
    .txSymValid(txSymValid), .pmaRxA(rA), .pmaRxB(rB), .rxd(rxd),
    .rxDv(rxDv), .rxErr(rxErr), .receiving(receiving), .locRcvrOk(locRcvrOk)
  );
  pps_pma_model pma (.clk(clk), .txA(pA), .txB(pB), .fault(fault), .rxA(rA), .rxB(rB));

  always #50 clk = ~clk;
  always @(negedge clk) begin
    if (receiving === 1'b1) sawRecv = 1'b1;
    if (rxDv === 1'b1) sawDv = 1'b1;
    if (rxErr === 1'b1) sawRxErr = 1'b1;
  end
  // long enough for every scenario with margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errorCnt++;
      tally_and_finish();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic isTwo(input logic [LVL_W-1:0] l);
    return l === LV_P2 || l === LV_M2;
  endfunction
  function automatic logic isOdd(input logic [LVL_W-1:0] l);
    return l === LV_P1 || l === LV_M1;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    d = regRdData;
  endtask
  // one nibble per period
  // afterwards the outputs show the previous call's period
  task automatic step(input logic en, input logic er, input logic [3:0] d);
    @(posedge clk);
    txEn <= en;
    txErr <= er;
    txd <= d;
    @(negedge clk);
    chk("symValid", 1, txSymValid);
  endtask
  task automatic pairs(input int n, input logic en);
    int gap;
    gap = 0;
    for (int i = 0; i < n; i++) begin
      step(en, 1'b0, 4'h0);
      gap = (isTwo(pA) || isTwo(pB)) ? 0 : gap + 1;
      chk("idlePair", 1, isOdd(pA) ^ isOdd(pB));
      chk("twoGap", 1, gap < 3);
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    rd(REG_CTRL, v);
    chk("ctrlRst", 32'h3, v);
    @(negedge clk);
    chk("rdIdle", 0, regRdData);
    rd(REG_SEED, v);
    chk("seedRst", SEED_RST, v);
    wr(REG_SEED, 32'ha5a5_0f0f);
    wr(8'h0c, 32'hffff_ffff);
    rd(REG_SEED, v);
    chk("seedRw", 32'ha5a5_0f0f, v);
    rd(8'h0c, v);
    chk("unmapped", 0, v);
    wr(REG_CTRL, 32'hb);
    rd(REG_CTRL, v);
    chk("reseedPulse", 32'h3, v);
  endtask
  task automatic t_idle;
    pairs(40, 1'b0);
    wr(REG_CTRL, 32'h2);
    pairs(40, 1'b0);
    wr(REG_CTRL, 32'h3);
  endtask
  task automatic t_health(input logic e);
    for (int i = 0; i < 600 && locRcvrOk !== e; i++) step(1'b0, 1'b0, 4'h0);
    chk("locOk", e, locRcvrOk);
    if (e) chk("rxdIdle", 1, (rxd[3:2] == 2'h1) ^ (rxd[1:0] == 2'h1));
  endtask
  task automatic t_frame;
    sawRecv = 1'b0;
    sawDv = 1'b0;
    step(1'b1, 1'b0, 4'h5);
    step(1'b1, 1'b0, 4'h5);
    chk("start1", 1, isTwo(pA) && isTwo(pB));
    step(1'b1, 1'b0, 4'h0);
    chk("start2", 1, isTwo(pA) && pB === LV_0);
    for (int i = 1; i <= 16; i++) begin
      step(1'b1, i == 16, i[3:0]);
      v = 32'(i - 1);
      chk("dataPar", (v[3] ^ v[2]) ^ (v[1] ^ v[0]) ^ 1, isOdd(pA) ^ isOdd(pB));
    end
    step(1'b0, 1'b0, 4'h0);
    chk("errSym", 1, (isTwo(pA) && pB === LV_0) || (isTwo(pB) && pA === LV_0));
    // first half of the end marker carries outer levels on both lanes
    step(1'b0, 1'b0, 4'h0);
    chk("endMark1", 1, isTwo(pA) && isTwo(pB));
    step(1'b0, 1'b0, 4'h0);
    chk("endMark2", 1, isTwo(pA) && pB === LV_0);
    pairs(3, 1'b0);
    chk("recvSeen", 1, sawRecv);
    chk("dvSeen", 1, sawDv);
    pairs(20, 1'b0);
    chk("recvEnd", 0, receiving);
    chk("dvEnd", 0, rxDv);
    chk("rxErrQuiet", 0, sawRxErr);
  endtask
  task automatic t_idleonly;
    wr(REG_CTRL, 32'h1);
    pairs(8, 1'b1);
    rd(REG_STATUS, v);
    chk("actOff", 0, v[ST_TXEN]);
    wr(REG_CTRL, 32'h3);
    rd(REG_STATUS, v);
    chk("actOn", 1, v[ST_TXEN]);
    // the short frame just started must finish its end marker first
    repeat (3) step(1'b0, 1'b0, 4'h0);
    pairs(20, 1'b0);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_idle();
    t_health(1'b1);
    t_frame();
    t_idleonly();
    fault <= 1'b1;
    t_health(1'b0);
    fault <= 1'b0;
    t_health(1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
